//--- rtl/dmc_pkg.sv
// Shared constants and types for the DDR2 configuration and initialisation block.
package dmc_pkg;

    // ------------------------------------------------------------------
    // Command codes on {RAS#, CAS#, WE#} with CS# low
    // ------------------------------------------------------------------
    localparam logic [2:0] CMD_LOAD = 3'h0;
    localparam logic [2:0] CMD_REFRESH = 3'h1;
    localparam logic [2:0] CMD_PRECHARGE = 3'h2;
    localparam logic [2:0] CMD_ACTIVATE = 3'h3;
    localparam logic [2:0] CMD_WRITE = 3'h4;
    localparam logic [2:0] CMD_READ = 3'h5;
    localparam logic [2:0] CMD_NOP = 3'h7;

    // ------------------------------------------------------------------
    // Register selection on BA1:BA0 and widths
    // ------------------------------------------------------------------
    localparam logic [1:0] BANK_BASE = 2'h0;
    localparam logic [1:0] BANK_EXT1 = 2'h1;
    localparam logic [1:0] BANK_EXT2 = 2'h2;
    localparam logic [1:0] BANK_EXT3 = 2'h3;
    localparam int REG_W = 13;
    localparam int ADDR_W = 16;
    localparam int BA_W = 3;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int DLL_OFF_BIT = 0;
    localparam int RTT_LO_BIT = 2;
    localparam int AL_LSB = 3;
    localparam int RTT_HI_BIT = 6;
    localparam int CAL_LSB = 7;
    localparam int FAST_REF_BIT = 7;
    localparam int CL_LSB = 4;
    localparam int DLL_RESET_BIT = 8;
    localparam int PRE_ALL_BIT = 10;
    localparam int BA_TOP_BIT = 2;

    // ------------------------------------------------------------------
    // Field values, reset values and counts
    // ------------------------------------------------------------------
    localparam logic [2:0] AL_MAX = 3'h6;
    localparam logic [2:0] CL_MIN = 3'h3;
    localparam logic [2:0] CAL_DEFAULT = 3'h7;
    localparam logic [2:0] CAL_EXIT = 3'h0;
    localparam logic [1:0] RTT_OFF = 2'h0;
    localparam logic [12:0] EXT_RESET = 13'h0000;
    localparam logic [12:0] BASE_RESET = 13'h0000;
    localparam logic [7:0] DLL_LOCK_CYCLES = 8'hC8;
    localparam logic [1:0] REFRESH_MIN = 2'h2;
    localparam int AL_DEPTH = 6;

    // ------------------------------------------------------------------
    // Initialisation progress, Gray coded along the sequence
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_WAIT_CKE = 4'h0,
        ST_WAIT_PRE1 = 4'h1,
        ST_WAIT_EXT2 = 4'h3,
        ST_WAIT_EXT3 = 4'h2,
        ST_WAIT_EXT1 = 4'h6,
        ST_WAIT_DLLRST = 4'h7,
        ST_WAIT_PRE2 = 4'h5,
        ST_WAIT_REF = 4'h4,
        ST_WAIT_BASE = 4'hC,
        ST_WAIT_CALDEF = 4'hD,
        ST_WAIT_CALEXIT = 4'hF,
        ST_DONE = 4'hE
    } dmc_init_state_t;

endpackage

//--- rtl/dmc_al_if.sv
// Interface carrying column commands into the additive latency delay line.
`timescale 1ns/1ps
interface dmc_al_if;
    logic rd_cmd;
    logic wr_cmd;
    logic [2:0] al;
    logic rd_int;
    logic wr_int;

    modport ctrl (output rd_cmd, output wr_cmd, output al, input rd_int, input wr_int);
    modport delay (input rd_cmd, input wr_cmd, input al, output rd_int, output wr_int);
endinterface

//--- rtl/dmc_al_delay.sv
// Delay line that holds READ and WRITE commands for the additive latency.
`timescale 1ns/1ps
module dmc_al_delay (
    input wire logic clk_i,
    input wire logic rstn_i,
    dmc_al_if.delay al_bus
);

    logic [dmc_pkg::AL_DEPTH:1] rd_pipe;
    logic [dmc_pkg::AL_DEPTH:1] wr_pipe;
    logic [dmc_pkg::AL_DEPTH:0] rd_tap;
    logic [dmc_pkg::AL_DEPTH:0] wr_tap;

    // Tap 0 is the live command, so a zero latency issues in the same cycle.
    assign rd_tap = {rd_pipe, al_bus.rd_cmd};
    assign wr_tap = {wr_pipe, al_bus.wr_cmd};

    genvar g;
    generate
        for (g = 1; g <= dmc_pkg::AL_DEPTH; g++) begin : g_stage
            always_ff @(posedge clk_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    rd_pipe[g] <= 1'b0;
                    wr_pipe[g] <= 1'b0;
                end else begin
                    rd_pipe[g] <= rd_tap[g-1];
                    wr_pipe[g] <= wr_tap[g-1];
                end
            end
        end
    endgenerate

    // A reserved latency code issues nothing rather than indexing past the line.
    // The latency must not change while commands are in flight.
    assign al_bus.rd_int = (al_bus.al > dmc_pkg::AL_MAX) ? 1'b0 : rd_tap[al_bus.al]; // R2
    assign al_bus.wr_int = (al_bus.al > dmc_pkg::AL_MAX) ? 1'b0 : wr_tap[al_bus.al]; // R2

    a_read_delay_two: assert property (@(posedge clk_i) disable iff (!rstn_i) // R2
        (al_bus.rd_cmd && al_bus.al == 3'h2 && $stable(al_bus.al)) |-> ##2 al_bus.rd_int)
        else $error("read not issued internally two clocks after command");
    a_write_no_early: assert property (@(posedge clk_i) disable iff (!rstn_i) // R2
        (al_bus.al == 3'h3 && $stable(al_bus.al) && !$past(al_bus.wr_cmd, 3)) |-> !al_bus.wr_int)
        else $error("write issued internally without a command three clocks before");

endmodule // dmc_al_delay

//--- rtl/dmc_init_cfg.sv
// DDR2 device side: extended configuration registers, latencies, termination, init tracking.
`timescale 1ns/1ps
// Contract
// R1: Additive latency field is three bits, values 0 to 6 only.
// R2: Column commands execute internally additive_latency clocks after arrival.
// R3: Read latency equals additive latency plus CAS latency.
// R4: Write latency is read latency minus one clock.
// R5: Two bits pick termination 50, 75, 150 ohms or off.
// R6: Termination follows the ODT pin, except in self refresh.
// R7: Controller drops ODT before entering self refresh.
// R8: Termination stays off until the first extended register load.
// R9: Controller holds ODT low eight clocks after enabling termination.
// R10: Driver calibration field stays at default outside initialisation.
// R11: Controller sets fast refresh bit when hot on extended-temperature parts.
// R12: Extended loads only with banks idle, then wait the set delay.
// R13: BA2 and address bits above A12 must be zero on loads.
// R14: Only NOP for 200 us, then CKE rises and stays high.
// R15: After 400 ns a PRECHARGE ALL with A10 high.
// R16: Then load register two, then register three with zeros.
// R17: Then load register one with A0 low to enable the loop.
// R18: Then base register load with A8 high resets the loop.
// R19: Then PRECHARGE ALL and at least two REFRESH commands.
// R20: Then base register load with A8 low and operating values.
// R21: Register one loaded with calibration all ones, then all zeros.
// R22: Device ready 200 clocks after the loop reset load.
// R23: CAS latency field accepts 3 to 7 clocks only.
// R24: Register one bit 0 enables the loop; enabling needs a reset.
// R25: Controller spaces init commands with NOPs for recovery delays.
module dmc_init_cfg (
    input wire logic CLK_SYS_I,
    input wire logic RSTN_I,
    input wire logic CKE_I,
    input wire logic CS_N_I,
    input wire logic RAS_N_I,
    input wire logic CAS_N_I,
    input wire logic WE_N_I,
    input wire logic [dmc_pkg::BA_W-1:0] BA_I,
    input wire logic [dmc_pkg::ADDR_W-1:0] ADDR_I,
    input wire logic ODT_I,
    output logic RTT_ON_O,
    output logic [1:0] RTT_CODE_O,
    output logic [2:0] ADDITIVE_LATENCY_O,
    output logic [2:0] CAS_LATENCY_O,
    output logic [3:0] READ_LATENCY_O,
    output logic [3:0] WRITE_LATENCY_O,
    output logic READ_ISSUE_O,
    output logic WRITE_ISSUE_O,
    output logic FAST_REFRESH_O,
    output logic DLL_ENABLED_O,
    output logic DLL_LOCKED_O,
    output logic SELF_REFRESH_O,
    output logic INIT_DONE_O,
    output logic CONFIG_ERROR_O
);

    // ------------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------------
    logic cke_prev_r;
    logic cmd_en;
    logic [2:0] cmd;
    logic is_load;
    logic is_pre_all;
    logic is_refresh;
    logic upper_bad;
    logic dll_rst_ev;
    logic sr_enter;
    logic sr_exit;

    assign cmd = {RAS_N_I, CAS_N_I, WE_N_I};
    // Commands only register while CKE is high on this and the previous edge.
    assign cmd_en = cke_prev_r && CKE_I && !CS_N_I;
    assign is_load = cmd_en && cmd == dmc_pkg::CMD_LOAD;
    assign is_pre_all = cmd_en && cmd == dmc_pkg::CMD_PRECHARGE && ADDR_I[dmc_pkg::PRE_ALL_BIT];
    assign is_refresh = cmd_en && cmd == dmc_pkg::CMD_REFRESH;
    assign upper_bad = BA_I[dmc_pkg::BA_TOP_BIT] || (ADDR_I[15:13] != 3'h0); // R13
    assign sr_enter = cke_prev_r && !CKE_I && !CS_N_I && cmd == dmc_pkg::CMD_REFRESH;
    assign sr_exit = SELF_REFRESH_O && CKE_I;
    assign dll_rst_ev = (is_load && BA_I[1:0] == dmc_pkg::BANK_BASE
                         && ADDR_I[dmc_pkg::DLL_RESET_BIT]) || sr_exit; // R18

    always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            cke_prev_r <= 1'b0;
        end else begin
            cke_prev_r <= CKE_I;
        end
    end

    // ------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------
    logic [12:0] ext1_r;
    logic [12:0] ext2_r;
    logic [12:0] ext3_r;
    logic [12:0] base_r;
    logic ext1_seen_r;

    always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            ext1_r <= dmc_pkg::EXT_RESET;
            ext2_r <= dmc_pkg::EXT_RESET;
            ext3_r <= dmc_pkg::EXT_RESET;
            base_r <= dmc_pkg::BASE_RESET;
            ext1_seen_r <= 1'b0;
        end else if (is_load) begin
            case (BA_I[1:0])
                dmc_pkg::BANK_EXT1: begin
                    ext1_r <= ADDR_I[12:0];
                    ext1_seen_r <= 1'b1; // R8
                end
                dmc_pkg::BANK_EXT2: ext2_r <= ADDR_I[12:0];
                dmc_pkg::BANK_EXT3: ext3_r <= ADDR_I[12:0];
                default: begin
                    // The loop reset bit clears itself once acted upon.
                    base_r <= ADDR_I[12:0] & ~(13'h0001 << dmc_pkg::DLL_RESET_BIT);
                end
            endcase
        end
    end

    logic [2:0] al_fld;
    logic [2:0] cl_fld;
    logic [1:0] rtt_fld;
    logic [4:0] lat_sum;

    assign al_fld = ext1_r[dmc_pkg::AL_LSB +: 3];
    assign cl_fld = base_r[dmc_pkg::CL_LSB +: 3];
    assign rtt_fld = {ext1_r[dmc_pkg::RTT_HI_BIT], ext1_r[dmc_pkg::RTT_LO_BIT]}; // R5
    assign lat_sum = {2'h0, al_fld} + {2'h0, cl_fld}; // R3

    // ------------------------------------------------------------------
    // Latencies and status outputs
    // ------------------------------------------------------------------
    logic load_err_r;
    logic reserved_now;

    assign reserved_now = (al_fld > dmc_pkg::AL_MAX) || (cl_fld < dmc_pkg::CL_MIN); // R1 R23

    always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            load_err_r <= 1'b0;
        end else if (is_load && upper_bad) begin
            load_err_r <= 1'b1; // R13
        end
    end

    always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            ADDITIVE_LATENCY_O <= 3'h0;
            CAS_LATENCY_O <= 3'h0;
            READ_LATENCY_O <= 4'h0;
            WRITE_LATENCY_O <= 4'h0;
            FAST_REFRESH_O <= 1'b0;
            DLL_ENABLED_O <= 1'b0;
            CONFIG_ERROR_O <= 1'b0;
        end else begin
            ADDITIVE_LATENCY_O <= al_fld;
            CAS_LATENCY_O <= cl_fld;
            READ_LATENCY_O <= lat_sum[3:0]; // R3
            // A zero sum only arises from reserved settings; it is held at zero.
            WRITE_LATENCY_O <= (lat_sum == 5'h00) ? 4'h0 : 4'(lat_sum - 5'h01); // R4
            FAST_REFRESH_O <= ext2_r[dmc_pkg::FAST_REF_BIT]; // R11
            DLL_ENABLED_O <= !ext1_r[dmc_pkg::DLL_OFF_BIT]; // R24
            CONFIG_ERROR_O <= load_err_r || reserved_now; // R1 R23
        end
    end

    // ------------------------------------------------------------------
    // Self refresh and termination
    // ------------------------------------------------------------------
    logic odt_ok;

    // Termination is cut once self refresh is registered, so an ODT still high at the entry edge keeps it on for one cycle.
    assign odt_ok = (rtt_fld != dmc_pkg::RTT_OFF) && ext1_seen_r && !SELF_REFRESH_O; // R6 R7 R8

    always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            SELF_REFRESH_O <= 1'b0;
        end else if (sr_enter) begin
            SELF_REFRESH_O <= 1'b1;
        end else if (sr_exit) begin
            SELF_REFRESH_O <= 1'b0;
        end
    end

    always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            RTT_ON_O <= 1'b0;
            RTT_CODE_O <= dmc_pkg::RTT_OFF;
        end else begin
            RTT_ON_O <= odt_ok && ODT_I; // R6
            RTT_CODE_O <= (odt_ok && ODT_I) ? rtt_fld : dmc_pkg::RTT_OFF; // R5
        end
    end

    // ------------------------------------------------------------------
    // Loop lock timer
    // ------------------------------------------------------------------
    logic [7:0] lock_cnt_r;
    logic lock_armed_r;

    always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            lock_cnt_r <= 8'h00;
            lock_armed_r <= 1'b0;
        end else if (dll_rst_ev) begin
            lock_cnt_r <= dmc_pkg::DLL_LOCK_CYCLES - 8'h01; // R22
            lock_armed_r <= 1'b1;
        end else if (lock_cnt_r != 8'h00) begin
            lock_cnt_r <= lock_cnt_r - 8'h01;
        end
    end

    assign DLL_LOCKED_O = DLL_ENABLED_O && lock_armed_r && lock_cnt_r == 8'h00; // R22

    // ------------------------------------------------------------------
    // Initialisation progress
    // ------------------------------------------------------------------
    dmc_pkg::dmc_init_state_t state_r;
    logic [1:0] ref_cnt_r;

    always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            ref_cnt_r <= 2'h0;
        end else if (state_r != dmc_pkg::ST_WAIT_REF) begin
            ref_cnt_r <= 2'h0;
        end else if (is_refresh && ref_cnt_r != dmc_pkg::REFRESH_MIN) begin
            ref_cnt_r <= ref_cnt_r + 2'h1; // R19
        end
    end

    always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            state_r <= dmc_pkg::ST_WAIT_CKE;
        end else begin
            case (state_r)
                dmc_pkg::ST_WAIT_CKE: begin
                    if (CKE_I) state_r <= dmc_pkg::ST_WAIT_PRE1; // R14
                end
                dmc_pkg::ST_WAIT_PRE1: begin
                    if (is_pre_all) state_r <= dmc_pkg::ST_WAIT_EXT2; // R15
                end
                dmc_pkg::ST_WAIT_EXT2: begin
                    if (is_load && BA_I[1:0] == dmc_pkg::BANK_EXT2) begin
                        state_r <= dmc_pkg::ST_WAIT_EXT3; // R16
                    end
                end
                dmc_pkg::ST_WAIT_EXT3: begin
                    if (is_load && BA_I[1:0] == dmc_pkg::BANK_EXT3) begin
                        state_r <= dmc_pkg::ST_WAIT_EXT1; // R16
                    end
                end
                dmc_pkg::ST_WAIT_EXT1: begin
                    if (is_load && BA_I[1:0] == dmc_pkg::BANK_EXT1 && !ADDR_I[0]) begin
                        state_r <= dmc_pkg::ST_WAIT_DLLRST; // R17
                    end
                end
                dmc_pkg::ST_WAIT_DLLRST: begin
                    if (dll_rst_ev && is_load) state_r <= dmc_pkg::ST_WAIT_PRE2; // R18
                end
                dmc_pkg::ST_WAIT_PRE2: begin
                    if (is_pre_all) state_r <= dmc_pkg::ST_WAIT_REF; // R19
                end
                dmc_pkg::ST_WAIT_REF: begin
                    if (ref_cnt_r == dmc_pkg::REFRESH_MIN) state_r <= dmc_pkg::ST_WAIT_BASE;
                end
                dmc_pkg::ST_WAIT_BASE: begin
                    if (is_load && BA_I[1:0] == dmc_pkg::BANK_BASE
                        && !ADDR_I[dmc_pkg::DLL_RESET_BIT]) begin
                        state_r <= dmc_pkg::ST_WAIT_CALDEF; // R20
                    end
                end
                dmc_pkg::ST_WAIT_CALDEF: begin
                    if (is_load && BA_I[1:0] == dmc_pkg::BANK_EXT1
                        && ADDR_I[dmc_pkg::CAL_LSB +: 3] == dmc_pkg::CAL_DEFAULT) begin
                        state_r <= dmc_pkg::ST_WAIT_CALEXIT; // R21
                    end
                end
                dmc_pkg::ST_WAIT_CALEXIT: begin
                    if (is_load && BA_I[1:0] == dmc_pkg::BANK_EXT1
                        && ADDR_I[dmc_pkg::CAL_LSB +: 3] == dmc_pkg::CAL_EXIT) begin
                        state_r <= dmc_pkg::ST_DONE; // R21
                    end
                end
                dmc_pkg::ST_DONE: state_r <= dmc_pkg::ST_DONE;
                default: state_r <= dmc_pkg::ST_WAIT_CKE;
            endcase
        end
    end

    assign INIT_DONE_O = state_r == dmc_pkg::ST_DONE && DLL_LOCKED_O; // R22

    // ------------------------------------------------------------------
    // Additive latency delay line
    // ------------------------------------------------------------------
    dmc_al_if al_bus ();

    assign al_bus.rd_cmd = cmd_en && cmd == dmc_pkg::CMD_READ;
    assign al_bus.wr_cmd = cmd_en && cmd == dmc_pkg::CMD_WRITE;
    assign al_bus.al = al_fld;
    assign READ_ISSUE_O = al_bus.rd_int; // R2
    assign WRITE_ISSUE_O = al_bus.wr_int; // R2

    dmc_al_delay u_al_delay (
        .clk_i(CLK_SYS_I),
        .rstn_i(RSTN_I),
        .al_bus(al_bus)
    );

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    logic [7:0] since_rst_r;

    always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            since_rst_r <= 8'h00;
        end else if (dll_rst_ev) begin
            since_rst_r <= 8'h01;
        end else if (since_rst_r != 8'hFF) begin
            since_rst_r <= since_rst_r + 8'h01;
        end
    end

    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (!RSTN_I);

    a_rl_sum_value: assert property (##1 READ_LATENCY_O == 4'($past(al_fld)) + 4'($past(cl_fld))) // R3
        else $error("read latency is not additive plus CAS latency");
    a_wl_minus_one: assert property (READ_LATENCY_O != 4'h0 |-> WRITE_LATENCY_O == READ_LATENCY_O - 4'h1) // R4
        else $error("write latency is not read latency minus one");
    a_odt_follow_pin: assert property ((odt_ok && ODT_I) |=> RTT_ON_O && RTT_CODE_O == $past(rtt_fld)) // R6
        else $error("termination did not follow ODT");
    a_odt_self_refresh: assert property (SELF_REFRESH_O |=> !RTT_ON_O) // R6
        else $error("termination on during self refresh");
    a_odt_before_load: assert property (!ext1_seen_r |=> !RTT_ON_O) // R8
        else $error("termination on before first extended load");
    a_lock_not_early: assert property (DLL_LOCKED_O |-> since_rst_r >= 8'hC8) // R22
        else $error("loop reported locked before 200 clocks");
    a_lock_on_time: assert property ((DLL_ENABLED_O && lock_armed_r && since_rst_r == 8'hC8) |-> DLL_LOCKED_O) // R22
        else $error("loop not locked 200 clocks after reset");
    a_al_reserved: assert property ((al_fld > dmc_pkg::AL_MAX) |=> CONFIG_ERROR_O) // R1
        else $error("reserved additive latency not flagged");

    c_init_done: cover property (state_r == dmc_pkg::ST_WAIT_CALEXIT ##1 state_r == dmc_pkg::ST_DONE);
    c_self_refresh: cover property (sr_enter ##[1:50] sr_exit);
    c_rtt_on: cover property ($rose(RTT_ON_O));

endmodule // dmc_init_cfg

//--- tb/dmc_ctrl_model.sv
// Behavioural DDR2 memory controller driving the command, clock enable and ODT pins.
`timescale 1ns/1ps
module dmc_ctrl_model (
    input wire logic clk_i,
    output logic cke_o,
    output logic cs_n_o,
    output logic ras_n_o,
    output logic cas_n_o,
    output logic we_n_o,
    output logic [2:0] ba_o,
    output logic [15:0] addr_o,
    output logic odt_o
);
    initial begin
        cke_o = 1'b0;
        odt_o = 1'b0;
        cs_n_o = 1'b1;
        {ras_n_o, cas_n_o, we_n_o} = dmc_pkg::CMD_NOP;
        ba_o = 3'h0;
        addr_o = 16'h0000;
    end

    task automatic nops(input int n);
        repeat (n) begin
            @(posedge clk_i);
            #10;
        end
    endtask

    task automatic pins(input logic cke, input logic odt);
        cke_o = cke;
        odt_o = odt;
    endtask

    // The idle address is inverted so a stale value can never pass for a fresh one.
    task automatic issue(input logic [2:0] cmd, input logic [2:0] ba, input logic [15:0] addr,
                         input int gap);
        cs_n_o = 1'b0;
        {ras_n_o, cas_n_o, we_n_o} = cmd;
        ba_o = ba;
        addr_o = addr;
        nops(1);
        cs_n_o = 1'b1;
        {ras_n_o, cas_n_o, we_n_o} = dmc_pkg::CMD_NOP;
        ba_o = ~ba;
        addr_o = ~addr;
        nops(gap);
    endtask

    // Upper address bits and the top bank bit stay zero on every load.
    task automatic init_seq();
        nops(2000);
        cke_o = 1'b1;
        nops(4);
        issue(dmc_pkg::CMD_PRECHARGE, 3'h0, 16'h0400, 1);
        issue(dmc_pkg::CMD_LOAD, 3'h2, 16'h0080, 1);
        issue(dmc_pkg::CMD_LOAD, 3'h3, 16'h0000, 1);
        issue(dmc_pkg::CMD_LOAD, 3'h1, 16'h0014, 1);
        issue(dmc_pkg::CMD_LOAD, 3'h0, 16'h0140, 1);
        issue(dmc_pkg::CMD_PRECHARGE, 3'h0, 16'h0400, 1);
        issue(dmc_pkg::CMD_REFRESH, 3'h0, 16'h0000, 1);
        issue(dmc_pkg::CMD_REFRESH, 3'h0, 16'h0000, 1);
        issue(dmc_pkg::CMD_LOAD, 3'h0, 16'h0040, 1);
        issue(dmc_pkg::CMD_LOAD, 3'h1, 16'h0394, 1);
        issue(dmc_pkg::CMD_LOAD, 3'h1, 16'h0014, 1);
    endtask
endmodule // dmc_ctrl_model

//--- tb/ddr2_ext_mode_config_and_init_tb.sv
// Self-checking bench for the DDR2 configuration and initialisation block.
`timescale 1ns/1ps
module ddr2_ext_mode_config_and_init_tb;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic cke, cs_n, ras_n, cas_n, we_n, odt;
    logic [2:0] ba;
    logic [15:0] addr;
    logic rtt_on, fast_ref, dll_en, dll_lock, sr, init_done, cfg_err, rd_iss, wr_iss;
    logic [1:0] rtt_code;
    logic [2:0] al, cl;
    logic [3:0] rl, wl;
    int fails = 0;
    int checks_done = 0;
    int cycles = 0;

    always #50 clk = ~clk;

    dmc_ctrl_model u_ctrl (.clk_i(clk), .cke_o(cke), .cs_n_o(cs_n), .ras_n_o(ras_n),
        .cas_n_o(cas_n), .we_n_o(we_n), .ba_o(ba), .addr_o(addr), .odt_o(odt));

    dmc_init_cfg u_dut (.CLK_SYS_I(clk), .RSTN_I(rstn), .CKE_I(cke), .CS_N_I(cs_n),
        .RAS_N_I(ras_n), .CAS_N_I(cas_n), .WE_N_I(we_n), .BA_I(ba), .ADDR_I(addr),
        .ODT_I(odt), .RTT_ON_O(rtt_on), .RTT_CODE_O(rtt_code), .ADDITIVE_LATENCY_O(al),
        .CAS_LATENCY_O(cl), .READ_LATENCY_O(rl), .WRITE_LATENCY_O(wl),
        .READ_ISSUE_O(rd_iss), .WRITE_ISSUE_O(wr_iss), .FAST_REFRESH_O(fast_ref),
        .DLL_ENABLED_O(dll_en), .DLL_LOCKED_O(dll_lock), .SELF_REFRESH_O(sr),
        .INIT_DONE_O(init_done), .CONFIG_ERROR_O(cfg_err));

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [3:0] got, input logic [3:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // The whole run needs about 2300 cycles.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            fails++;
            end_of_test();
        end
    end

    initial begin
        repeat (4) @(posedge clk);
        #10 rstn = 1'b1;
        chk(init_done, 1'b0);
        u_ctrl.init_seq();
        chk(fast_ref, 1'b1);
        chk(dll_en, 1'b1);
        chk(al, 4'h2);
        chk(cl, 4'h4);
        chk(rl, 4'h6);
        chk(wl, 4'h5);
        u_ctrl.nops(185);
        chk(init_done, 1'b0);
        u_ctrl.nops(2);
        chk(init_done, 1'b1);
        chk(dll_lock, 1'b1);
        // Every termination code, each after the quiet time that enabling demands.
        for (int i = 0; i < 4; i++) begin
            u_ctrl.issue(dmc_pkg::CMD_LOAD, 3'h1,
                16'h0010 | (i[1] ? 16'h0040 : 16'h0000) | (i[0] ? 16'h0004 : 16'h0000), 8);
            u_ctrl.pins(1'b1, 1'b1);
            u_ctrl.nops(1);
            chk(rtt_code, 4'(i));
            chk(rtt_on, i != 0);
            u_ctrl.pins(1'b1, 1'b0);
            u_ctrl.nops(1);
            chk(rtt_on, 1'b0);
        end
        // Column commands wait exactly the additive latency, up to its largest value.
        // Reads go with latencies 1, 2, 5 and 6, writes with 3 and 4.
        for (int a = 1; a < 7; a++) begin
            u_ctrl.issue(dmc_pkg::CMD_LOAD, 3'h1, {10'h000, a[2:0], 3'h0}, 1);
            chk(rl, 4'(a + 4));
            chk(wl, 4'(a + 3));
            u_ctrl.issue((a[1] ^ a[0]) ? dmc_pkg::CMD_READ : dmc_pkg::CMD_WRITE, 3'h0, 16'h0000, 0);
            u_ctrl.nops(a - 1);
            chk((a[1] ^ a[0]) ? rd_iss : wr_iss, 1'b1);
            chk((a[1] ^ a[0]) ? wr_iss : rd_iss, 1'b0);
            u_ctrl.nops(1);
            chk(rd_iss | wr_iss, 1'b0);
        end
        chk(cfg_err, 1'b0);
        u_ctrl.issue(dmc_pkg::CMD_LOAD, 3'h1, 16'h0038, 1);
        chk(cfg_err, 1'b1);
        u_ctrl.issue(dmc_pkg::CMD_LOAD, 3'h1, 16'h0014, 8);
        chk(cfg_err, 1'b0);
        u_ctrl.issue(dmc_pkg::CMD_LOAD, 3'h2, 16'h8000, 1);
        chk(cfg_err, 1'b1);
        chk(fast_ref, 1'b0);
        u_ctrl.pins(1'b0, 1'b0);
        u_ctrl.issue(dmc_pkg::CMD_REFRESH, 3'h0, 16'h0000, 0);
        chk(sr, 1'b1);
        u_ctrl.pins(1'b0, 1'b1);
        u_ctrl.nops(2);
        chk(rtt_on, 1'b0);
        u_ctrl.pins(1'b1, 1'b0);
        u_ctrl.nops(2);
        chk(sr, 1'b0);
        // A reset in mid-run clears every setting, so the reserved zero CAS latency shows again.
        rstn = 1'b0;
        u_ctrl.nops(1);
        chk(al, 4'h0);
        chk(dll_en, 1'b0);
        chk(cfg_err, 1'b0);
        rstn = 1'b1;
        u_ctrl.nops(1);
        chk(cfg_err, 1'b1);
        chk(init_done, 1'b0);
        end_of_test();
    end
endmodule // ddr2_ext_mode_config_and_init_tb
